// *** pkg/smcg_pkg.sv ***
// shared constants and types of the sleep-mode clock gating block
package smcg_pkg;
	// register map, byte addresses on the register bus
	localparam int             ADDR_W          = 8;
	localparam logic [7:0]     OFS_SLEEP_CTRL  = 8'h00;
	localparam logic [7:0]     OFS_COMP_CTRL   = 8'h04;
	localparam logic [7:0]     OFS_STATUS      = 8'h08;
	// sleep_control_reg fields
	localparam int             SE_BIT          = 0;
	localparam int             SM_LSB          = 1;
	localparam int             SM_MSB          = 3;
	localparam logic [3:0]     SCTRL_RESET     = 4'h0;
	// comparator_ctrl_status field
	localparam int             ACD_BIT         = 0;
	localparam logic           ACD_RESET       = 1'b0;
	// status register fields
	localparam int             ST_STATE_LSB    = 0;
	localparam int             ST_MODE_LSB     = 4;
	localparam int             ST_CMP_BIT      = 7;
	// sleep_mode_select codes
	localparam logic [2:0]     MODE_IDLE       = 3'h0;
	localparam logic [2:0]     MODE_ADCNR      = 3'h1;
	localparam logic [2:0]     MODE_PDOWN      = 3'h2;
	localparam logic [2:0]     MODE_PSAVE      = 3'h3;
	localparam logic [2:0]     MODE_STANDBY    = 3'h6;
	// clock_source_fuses code class that means external crystal/resonator
	localparam logic [2:0]     FUSE_XTAL_CLASS = 3'h7;
	// timing counts in cycles of the 10 MHz clock
	localparam int             CNT_W           = 16;
	localparam logic [15:0]    HOLD_CYC        = 16'h0004;
	localparam logic [15:0]    STANDBY_WAKE_CYC = 16'h0006;
	localparam logic [15:0]    STANDBY_START_CYC = STANDBY_WAKE_CYC - HOLD_CYC;

	typedef enum logic [3:0] {
		SMCG_RUN     = 4'h1,
		SMCG_SLEEP   = 4'h2,
		SMCG_STARTUP = 4'h4,
		SMCG_HOLD    = 4'h8
	} smcg_state_t;
endpackage

// *** hdl/smcg_cycle_counter.sv ***
// loadable down counter for the start-up and core hold delays
`timescale 1ns/100ps
`default_nettype none
module smcg_cycle_counter #(
	parameter int W = 16
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rstn_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	output logic              last_out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load_in) begin
			cnt_d = value_in;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// a load of n ends the wait after n cycles
	assign last_out = (cnt_q <= {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** hdl/smcg_wake_filter.sv ***
// per-mode qualification of the wake-up interrupt sources
`timescale 1ns/100ps
`default_nettype none
module smcg_wake_filter
	import smcg_pkg::*;
(
	input  wire logic [2:0] mode_in,
	input  wire logic       comparator_disable_in,
	input  wire logic       ext_irq_zero_req_in,
	input  wire logic       ext_irq_zero_level_in,
	input  wire logic       pin_change_irq_in,
	input  wire logic       start_cond_irq_in,
	input  wire logic       display_irq_in,
	input  wire logic       timer2_ovf_irq_in,
	input  wire logic       timer2_cmp_irq_in,
	input  wire logic [1:0] timer2_irq_mask_in,
	input  wire logic       global_irq_enable_in,
	input  wire logic       store_ready_irq_in,
	input  wire logic       adc_done_irq_in,
	input  wire logic       comparator_irq_in,
	input  wire logic       other_irq_in,
	output logic            wake_irq_out
);
	logic ext0_lvl;
	logic t2_ok;
	logic async_set;

	always_comb begin
		// in the stopped-clock modes only a level on ext_irq_zero is seen
		ext0_lvl  = ext_irq_zero_req_in & ext_irq_zero_level_in;
		t2_ok     = global_irq_enable_in &
		            ((timer2_ovf_irq_in & timer2_irq_mask_in[0]) |
		             (timer2_cmp_irq_in & timer2_irq_mask_in[1]));
		async_set = start_cond_irq_in | ext0_lvl | pin_change_irq_in;
		case (mode_in)
			MODE_IDLE: begin
				wake_irq_out = ext_irq_zero_req_in | pin_change_irq_in |
				               start_cond_irq_in | display_irq_in | t2_ok |
				               store_ready_irq_in | adc_done_irq_in |
				               other_irq_in |
				               (comparator_irq_in & ~comparator_disable_in);
			end
			MODE_ADCNR: begin
				wake_irq_out = adc_done_irq_in | display_irq_in |
				               start_cond_irq_in | t2_ok |
				               store_ready_irq_in | ext0_lvl |
				               pin_change_irq_in;
			end
			MODE_PSAVE: begin
				wake_irq_out = async_set | t2_ok | display_irq_in;
			end
			default: begin
				wake_irq_out = async_set;
			end
		endcase
	end
endmodule
`default_nettype wire

// *** hdl/smcg_top.sv ***
// sleep-mode controller: mode decode, clock gating and wake sequencing
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module smcg_top
	import smcg_pkg::*;
#(
	parameter logic [15:0] STARTUP_XTAL_CYC = 16'h0400,
	parameter logic [15:0] STARTUP_RC_CYC   = 16'h0040
) (
	input  wire logic                      sys_clk_in,
	input  wire logic                      rstn_in,
	input  wire logic [smcg_pkg::ADDR_W-1:0] avs_address_in,
	input  wire logic                      avs_read_in,
	input  wire logic                      avs_write_in,
	input  wire logic [31:0]               avs_writedata_in,
	output logic [31:0]                    avs_readdata_out,
	output logic                           avs_waitrequest_out,
	input  wire logic                      sleep_instr_in,
	input  wire logic [3:0]                clock_source_fuses_in,
	input  wire logic                      adc_enabled_in,
	input  wire logic                      timer2_enabled_in,
	input  wire logic                      timer2_async_in,
	input  wire logic                      display_enabled_in,
	input  wire logic                      display_async_in,
	input  wire logic                      ext_reset_n_pin_in,
	input  wire logic                      wdt_reset_in,
	input  wire logic                      bod_reset_in,
	input  wire logic                      ext_irq_zero_req_in,
	input  wire logic                      ext_irq_zero_level_in,
	input  wire logic                      pin_change_irq_in,
	input  wire logic                      start_cond_irq_in,
	input  wire logic                      display_irq_in,
	input  wire logic                      timer2_ovf_irq_in,
	input  wire logic                      timer2_cmp_irq_in,
	input  wire logic [1:0]                timer2_irq_mask_in,
	input  wire logic                      global_irq_enable_in,
	input  wire logic                      store_ready_irq_in,
	input  wire logic                      adc_done_irq_in,
	input  wire logic                      comparator_irq_in,
	input  wire logic                      other_irq_in,
	output logic                           core_clk_en_out,
	output logic                           flash_clk_en_out,
	output logic                           io_clk_en_out,
	output logic                           adc_clk_en_out,
	output logic                           async_clk_en_out,
	output logic                           periph_sync_clk_en_out,
	output logic                           main_osc_en_out,
	output logic                           timer_osc_en_out,
	output logic                           comparator_pwr_en_out,
	output logic                           adc_start_out,
	output logic                           resume_irq_out,
	output logic                           sleeping_out
);
	import smcg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// register bus slave
	logic [3:0]  sctrl_q, sctrl_d;
	logic        acd_q, acd_d;
	logic        waitreq_q, waitreq_d;
	logic [31:0] rdata_q, rdata_d;
	logic        bus_take;
	smcg_state_t state_q, state_d;
	logic [2:0]  mode_q, mode_d;

	always_comb begin
		sctrl_d   = sctrl_q;
		acd_d     = acd_q;
		rdata_d   = rdata_q;
		// one wait cycle per access, so read data always come from a flop
		waitreq_d = !((avs_read_in || avs_write_in) && waitreq_q);
		bus_take  = avs_write_in && !waitreq_q;
		if ((avs_read_in || avs_write_in) && waitreq_q) begin
			rdata_d = 32'h0000_0000;
			case (avs_address_in)
				OFS_SLEEP_CTRL: rdata_d[3:0] = sctrl_q;
				OFS_COMP_CTRL:  rdata_d[ACD_BIT] = acd_q;
				OFS_STATUS: begin
					rdata_d[ST_STATE_LSB +: 4] = state_q;
					rdata_d[ST_MODE_LSB +: 3]  = mode_q;
					rdata_d[ST_CMP_BIT]        = comparator_pwr_en_out;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		if (bus_take && avs_address_in == OFS_SLEEP_CTRL) begin
			sctrl_d = avs_writedata_in[3:0];
		end
		if (bus_take && avs_address_in == OFS_COMP_CTRL) begin
			acd_d = avs_writedata_in[ACD_BIT];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			sctrl_q   <= SCTRL_RESET;
			acd_q     <= ACD_RESET;
			waitreq_q <= 1'b1;
			rdata_q   <= 32'h0000_0000;
		end else begin
			sctrl_q   <= sctrl_d;
			acd_q     <= acd_d;
			waitreq_q <= waitreq_d;
			rdata_q   <= rdata_d;
		end
	end

	assign avs_waitrequest_out = waitreq_q;
	assign avs_readdata_out    = rdata_q;

	////////////////////////////////////////////////////////////////////
	// reset pin synchroniser and wake sources
	logic rst_meta_q, rst_sync_q;
	logic wake_rst, wake_irq, cnt_last, xtal_sel;

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= 1'b1;
		end else begin
			rst_meta_q <= ext_reset_n_pin_in;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign wake_rst = !rst_sync_q || wdt_reset_in || bod_reset_in;
	assign xtal_sel = (clock_source_fuses_in[3:1] == FUSE_XTAL_CLASS);

	smcg_wake_filter u_filter (
		.mode_in               (mode_q),
		.comparator_disable_in (acd_q),
		.ext_irq_zero_req_in   (ext_irq_zero_req_in),
		.ext_irq_zero_level_in (ext_irq_zero_level_in),
		.pin_change_irq_in     (pin_change_irq_in),
		.start_cond_irq_in     (start_cond_irq_in),
		.display_irq_in        (display_irq_in),
		.timer2_ovf_irq_in     (timer2_ovf_irq_in),
		.timer2_cmp_irq_in     (timer2_cmp_irq_in),
		.timer2_irq_mask_in    (timer2_irq_mask_in),
		.global_irq_enable_in  (global_irq_enable_in),
		.store_ready_irq_in    (store_ready_irq_in),
		.adc_done_irq_in       (adc_done_irq_in),
		.comparator_irq_in     (comparator_irq_in),
		.other_irq_in          (other_irq_in),
		.wake_irq_out          (wake_irq)
	);

	////////////////////////////////////////////////////////////////////
	// sleep sequencer
	logic        irqw_q, irqw_d;
	logic        cnt_load;
	logic [15:0] cnt_val, start_cyc;
	logic [2:0]  req_mode;
	logic        mode_ok, adc_start_d, resume_d;

	smcg_cycle_counter #(.W(CNT_W)) u_cnt (
		.sys_clk_in (sys_clk_in),
		.rstn_in    (rstn_in),
		.load_in    (cnt_load),
		.value_in   (cnt_val),
		.last_out   (cnt_last)
	);

	always_comb begin
		req_mode = sctrl_q[SM_MSB:SM_LSB];
		// standby without a crystal falls back to power-down
		if (req_mode == MODE_STANDBY && !xtal_sel) begin
			req_mode = MODE_PDOWN;
		end
		mode_ok = (req_mode == MODE_IDLE) || (req_mode == MODE_ADCNR) ||
		          (req_mode == MODE_PDOWN) || (req_mode == MODE_PSAVE) ||
		          (req_mode == MODE_STANDBY);
		case (mode_q)
			MODE_PDOWN, MODE_PSAVE: begin
				start_cyc = xtal_sel ? STARTUP_XTAL_CYC : STARTUP_RC_CYC;
			end
			MODE_STANDBY: start_cyc = STANDBY_START_CYC;
			default:      start_cyc = 16'h0000;
		endcase
	end

	always_comb begin
		state_d     = state_q;
		mode_d      = mode_q;
		irqw_d      = irqw_q;
		cnt_load    = 1'b0;
		cnt_val     = HOLD_CYC;
		adc_start_d = 1'b0;
		resume_d    = 1'b0;
		case (state_q)
			SMCG_RUN: begin
				// reserved codes leave every clock running
				if (sleep_instr_in && sctrl_q[SE_BIT] && mode_ok) begin
					state_d     = SMCG_SLEEP;
					mode_d      = req_mode;
					adc_start_d = adc_enabled_in &&
					              (req_mode == MODE_IDLE ||
					               req_mode == MODE_ADCNR);
				end
			end
			SMCG_SLEEP: begin
				if (wake_rst || wake_irq) begin
					irqw_d   = !wake_rst;
					cnt_load = 1'b1;
					if (start_cyc != 16'h0000) begin
						state_d = SMCG_STARTUP;
						cnt_val = start_cyc;
					end else if (!wake_rst) begin
						state_d = SMCG_HOLD;
					end else begin
						state_d = SMCG_RUN;
					end
				end
			end
			SMCG_STARTUP: begin
				if (cnt_last) begin
					cnt_load = 1'b1;
					state_d  = irqw_q ? SMCG_HOLD : SMCG_RUN;
				end
			end
			SMCG_HOLD: begin
				if (cnt_last) begin
					state_d  = SMCG_RUN;
					resume_d = 1'b1;
				end
			end
			default: state_d = SMCG_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// clock domain and oscillator gating
	logic async_use, sync_use;
	logic [8:0] gate_d, gate_q;

	always_comb begin
		async_use = (timer2_enabled_in && timer2_async_in) ||
		            (display_enabled_in && display_async_in);
		sync_use  = (timer2_enabled_in && !timer2_async_in) ||
		            (display_enabled_in && !display_async_in);
		// order: core flash io adc async periph_sync main tosc comparator
		gate_d = {8'hFF, 1'b0};
		gate_d[1] = async_use;
		gate_d[0] = !acd_q;
		case (state_d)
			SMCG_SLEEP, SMCG_STARTUP: begin
				case (mode_d)
					MODE_IDLE: gate_d[8:7] = 2'h0;
					MODE_ADCNR: begin
						gate_d[8:6] = 3'h0;
						// async timer 2 and display keep their clock here
						gate_d[4]   = 1'b1;
					end
					MODE_PSAVE: begin
						gate_d[8:5] = 4'h0;
						gate_d[4] = async_use;
						gate_d[3] = sync_use;
						gate_d[2] = sync_use;
						gate_d[0] = 1'b0;
					end
					default: begin
						// power-down and standby; standby keeps the oscillator
						gate_d[8:3] = 6'h00;
						gate_d[2]   = (mode_d == MODE_STANDBY);
						gate_d[1]   = 1'b0;
						gate_d[0]   = 1'b0;
					end
				endcase
				// oscillator must run while the clock restarts
				if (state_d == SMCG_STARTUP) begin
					gate_d[2] = 1'b1;
				end
			end
			SMCG_HOLD: gate_d[8:7] = 2'h0;
			default: gate_d[8:7] = 2'h3;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state_q        <= SMCG_RUN;
			mode_q         <= MODE_IDLE;
			irqw_q         <= 1'b0;
			// timer oscillator stays off until some module uses it
			gate_q         <= 9'h1FD;
			adc_start_out  <= 1'b0;
			resume_irq_out <= 1'b0;
			sleeping_out   <= 1'b0;
		end else begin
			state_q        <= state_d;
			mode_q         <= mode_d;
			irqw_q         <= irqw_d;
			gate_q         <= gate_d;
			adc_start_out  <= adc_start_d;
			resume_irq_out <= resume_d;
			sleeping_out   <= (state_d != SMCG_RUN);
		end
	end

	assign {core_clk_en_out, flash_clk_en_out, io_clk_en_out,
	        adc_clk_en_out, async_clk_en_out, periph_sync_clk_en_out,
	        main_osc_en_out, timer_osc_en_out, comparator_pwr_en_out} = gate_q;

	////////////////////////////////////////////////////////////////////
	// checks
	AST_SLEEP_NEEDS_SE: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(sleeping_out) |-> $past(sleep_instr_in) && $past(sctrl_q[SE_BIT])
	) else $error("entered sleep without sleep enable");

	AST_HOLD_FOUR: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(state_q == SMCG_HOLD) |->
			!core_clk_en_out [*4] ##1 core_clk_en_out
	) else $error("core hold after wake is not four cycles");

	AST_IDLE_GATES: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_IDLE) |->
			!core_clk_en_out && !flash_clk_en_out && io_clk_en_out &&
			adc_clk_en_out && main_osc_en_out
	) else $error("idle gating wrong");

	AST_COMP_OFF: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		acd_q && $past(acd_q) |-> !comparator_pwr_en_out
	) else $error("comparator powered while disabled");

	AST_ADC_AUTOSTART: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		adc_start_out |-> $rose(sleeping_out) && $past(adc_enabled_in) &&
			(mode_q == MODE_IDLE || mode_q == MODE_ADCNR)
	) else $error("conversion start outside idle or noise reduction entry");

	AST_ADCNR_GATES: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_ADCNR) |->
			!io_clk_en_out && !core_clk_en_out && adc_clk_en_out
	) else $error("noise reduction gating wrong");

	AST_PDOWN_GATES: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_PDOWN) |->
			!main_osc_en_out && !timer_osc_en_out && !async_clk_en_out &&
			!io_clk_en_out && !adc_clk_en_out
	) else $error("power-down left a clock running");

	AST_PDOWN_NO_TIMER: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_PDOWN && !wake_rst &&
		 !start_cond_irq_in && !pin_change_irq_in && !ext_irq_zero_req_in)
			|=> state_q == SMCG_SLEEP
	) else $error("power-down woke on a source it must ignore");

	AST_PSAVE_T2_MASK: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_PSAVE &&
		 !global_irq_enable_in && !wake_rst && !display_irq_in &&
		 !start_cond_irq_in && !pin_change_irq_in && !ext_irq_zero_req_in)
			|=> state_q == SMCG_SLEEP
	) else $error("power-save woke on timer 2 without global enable");

	AST_PSAVE_SYNC_ONLY: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_PSAVE) |->
			!io_clk_en_out && !adc_clk_en_out &&
			(periph_sync_clk_en_out == main_osc_en_out)
	) else $error("power-save sync clock leaked to other modules");

	AST_STANDBY_SIX: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_SLEEP && mode_q == MODE_STANDBY && wake_irq &&
		 !wake_rst) |=> ##[1:6] core_clk_en_out
	) else $error("standby wake slower than six cycles");

	AST_RESERVED_RUNS: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == SMCG_RUN && sleep_instr_in && !mode_ok) |=>
			state_q == SMCG_RUN && core_clk_en_out
	) else $error("reserved mode code stopped the core");
endmodule
`default_nettype wire

// *** testbench/smcg_core_model.sv ***
// behavioural core and peripheral model facing the sleep controller
`timescale 1ns/100ps
`default_nettype none
module smcg_core_model (
	input  wire logic sys_clk_in,
	input  wire logic core_clk_en_in,
	input  wire logic resume_irq_in,
	output logic      sleep_instr_out,
	output logic      ext_irq_zero_out
);
	initial begin
		sleep_instr_out = 1'b0;
		ext_irq_zero_out = 1'b0;
	end
	// a gated core cannot execute, so wait for its clock first
	task automatic exec_sleep();
		while (core_clk_en_in !== 1'b1) @(posedge sys_clk_in);
		sleep_instr_out <= 1'b1;
		@(posedge sys_clk_in);
		sleep_instr_out <= 1'b0;
	endtask
	// called just after an edge; the level stays until the core resumes
	task automatic raise_level();
		ext_irq_zero_out <= 1'b1;
	endtask
	always @(posedge sys_clk_in) begin
		if (resume_irq_in === 1'b1) begin
			ext_irq_zero_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the sleep-mode clock gating block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import smcg_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic        wreq, adc_en = 1'b1, wdt = 1'b0, gie = 1'b1;
	logic        t2_en = 1'b0, t2_as = 1'b0;
	logic [3:0]  nosleep [4] = '{4'h0, 4'h9, 4'hB, 4'hF};
	logic        adc_st, resume, sleeping, ext0, sl_in;
	logic        core, flash, io, adc, aclk, psync, mosc, tosc, cmp;
	logic [3:0]  fuses = 4'h0;
	logic [1:0]  t2_mask = 2'h1;
	logic [8:0]  irq = 9'h000;
	int          fails = 0, tests_run = 0;
	always #50 clk = ~clk;
	smcg_top #(.STARTUP_XTAL_CYC(16'h0002), .STARTUP_RC_CYC(16'h0002)) dut_u (
		.sys_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.sleep_instr_in(sl_in), .clock_source_fuses_in(fuses),
		.adc_enabled_in(adc_en), .timer2_enabled_in(t2_en),
		.timer2_async_in(t2_as), .display_enabled_in(t2_en),
		.display_async_in(t2_as), .ext_reset_n_pin_in(1'b1),
		.wdt_reset_in(wdt), .bod_reset_in(1'b0),
		.ext_irq_zero_req_in(ext0), .ext_irq_zero_level_in(1'b1),
		.pin_change_irq_in(irq[0]), .start_cond_irq_in(irq[1]),
		.display_irq_in(irq[2]), .timer2_ovf_irq_in(irq[3]),
		.timer2_cmp_irq_in(irq[4]), .timer2_irq_mask_in(t2_mask),
		.global_irq_enable_in(gie), .store_ready_irq_in(irq[5]),
		.adc_done_irq_in(irq[6]), .comparator_irq_in(irq[7]),
		.other_irq_in(irq[8]), .core_clk_en_out(core),
		.flash_clk_en_out(flash), .io_clk_en_out(io),
		.adc_clk_en_out(adc), .async_clk_en_out(aclk),
		.periph_sync_clk_en_out(psync), .main_osc_en_out(mosc),
		.timer_osc_en_out(tosc), .comparator_pwr_en_out(cmp),
		.adc_start_out(adc_st), .resume_irq_out(resume),
		.sleeping_out(sleeping));
	smcg_core_model core_u (.sys_clk_in(clk), .core_clk_en_in(core),
		.resume_irq_in(resume), .sleep_instr_out(sl_in),
		.ext_irq_zero_out(ext0));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// one Avalon access; hold everything until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		addr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		chk("waitrequest", 32'h0, {31'h0, wreq});
		// let one edge pass so a following call never re-raises at once
		@(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic logic [31:0] gates();
		return {24'h0, core, flash, io, adc, aclk, psync, mosc, tosc};
	endfunction
	// enter a mode, try a source that must not wake, then one that must
	task automatic run_mode(input logic [3:0] ctl, input logic [7:0] g,
		input int bad, input int good, input int wn);
		int n;
		bus(1'b1, OFS_SLEEP_CTRL, {28'h0, ctl}, q);
		core_u.exec_sleep();
		@(posedge clk);
		chk("gates", {24'h0, g}, gates());
		chk("adc start", {31'h0, ctl[3:1] < 3'h2 && adc_en},
			{31'h0, adc_st});
		irq[bad] <= 1'b1;
		repeat (10) @(posedge clk);
		chk("sleeping", 32'h1, {31'h0, sleeping});
		// overflow is unmasked here, so only the global enable holds it off
		if (ctl[3:1] == MODE_PSAVE) begin
			gie <= 1'b0;
			irq[3] <= 1'b1;
			repeat (4) @(posedge clk);
			chk("t2 no global enable", 32'h1, {31'h0, sleeping});
		end
		irq[bad] <= 1'b0;
		@(posedge clk);
		gie <= 1'b1;
		if (good == 9) core_u.raise_level();
		else irq[good] <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (resume !== 1'b1 && n < 40);
		chk("wake cycles", wn, n);
		irq <= 9'h000;
		@(posedge clk);
		chk("awake gates", 32'hFE | {31'h0, t2_en & t2_as}, gates());
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("gates after reset", 32'hFE, gates());
		bus(1'b0, OFS_SLEEP_CTRL, 32'h0, q);
		chk("ctrl reset", 32'h0, q);
		bus(1'b1, 8'h0C, 32'hFF, q);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		bus(1'b1, OFS_COMP_CTRL, 32'h1, q);
		bus(1'b0, OFS_COMP_CTRL, 32'h0, q);
		chk("comp ctrl", 32'h1, q);
		chk("comp power", 32'h0, {31'h0, cmp});
		bus(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", 32'h01, q);
		foreach (nosleep[i]) begin
			bus(1'b1, OFS_SLEEP_CTRL, {28'h0, nosleep[i]}, q);
			core_u.exec_sleep();
			repeat (2) @(posedge clk);
			chk("no sleep", 32'hFE, gates());
		end
		run_mode(4'h1, 8'h3E, 7, 8, 6);
		adc_en <= 1'b0;
		run_mode(4'h3, 8'h1E, 8, 6, 6);
		run_mode(4'h5, 8'h00, 3, 9, 8);
		// power-save is only chosen while timer 2 runs
		t2_en <= 1'b1;
		t2_as <= 1'b1;
		run_mode(4'h7, 8'h09, 4, 3, 8);
		t2_en <= 1'b0;
		t2_as <= 1'b0;
		fuses <= 4'hE;
		run_mode(4'hD, 8'h02, 2, 1, 8);
		// a watchdog reset ends power-down with no core hold and no resume
		bus(1'b1, OFS_SLEEP_CTRL, 32'h5, q);
		core_u.exec_sleep();
		wdt <= 1'b1;
		@(posedge clk);
		chk("asleep before reset", 32'h1, {31'h0, sleeping});
		wdt <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reset wake", 32'h0, {31'h0, sleeping});
		chk("no resume", 32'h0, {31'h0, resume});
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
